/* File: dpml_map.svh */
// Constants of the dual-controller parallel message link, slave end
`ifndef DPML_MAP_SVH
`define DPML_MAP_SVH
`define DPML_CLK_MHZ      20
`define DPML_STB_LOW_NS   100
`define DPML_SETUP_NS     50
`define DPML_RELEASE_NS   100
// Least times, rounded up to whole cycles
`define DPML_STB_LOW_CYC  ((`DPML_STB_LOW_NS*`DPML_CLK_MHZ+999)/1000)
`define DPML_SETUP_CYC    ((`DPML_SETUP_NS*`DPML_CLK_MHZ+999)/1000)
`define DPML_RELEASE_CYC  ((`DPML_RELEASE_NS*`DPML_CLK_MHZ+999)/1000)
`define DPML_BUS_IDLE     8'hff
`define DPML_NAK_LEN      8'h00
`endif

/* File: dpml_pkg.sv */
// Types of the dual-controller parallel message link
package dpml_pkg;
  typedef enum logic [8:0] {
    ST_RX_IDLE = 9'h001,
    ST_RX_LOW  = 9'h002,
    ST_RX_ANS  = 9'h004,
    ST_ACK_GET = 9'h008,
    ST_TX_SET  = 9'h010,
    ST_TX_STB  = 9'h020,
    ST_TX_WAIT = 9'h040,
    ST_TX_LOW  = 9'h080,
    ST_REL     = 9'h100
  } dpml_state_t;
endpackage

/* File: dpml_slave.sv */
// Slave end of the byte-wide parallel message link
// Contract
// - Shared 8-bit data bus, one shared strobe
// - First byte is total message length
// - Command received first, then acknowledge sent
// - Unknown command answered with zero length
// - Slave reads byte, answers with own pulse
// - Slave drives ack byte, then pulses strobe
// - Next ack byte only after master pulse
// - Slave drives all ones after last ack
// - Link reset low resets the slave
`include "dpml_map.svh"
module dpml_slave
  import dpml_pkg::*;
(
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       slave_reset_n,
  // Link data bus
  input  wire logic [7:0] link_data_bus_in,
  output logic      [7:0] link_data_bus_out,
  output logic            link_data_bus_oe,
  // Link strobe
  input  wire logic       handshake_strobe_n_in,
  output logic            handshake_strobe_n_out,
  output logic            handshake_strobe_n_oe,
  // Received command bytes
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic      [7:0] cmd_data,
  output logic            cmd_last,
  // Acknowledge bytes
  input  wire logic       ack_valid,
  output logic            ack_ready,
  input  wire logic [7:0] ack_data,
  input  wire logic       ack_nak
);
  // ==========================================================
  // Reset and strobe edge
  // ==========================================================
  logic        rst_n;
  assign rst_n = reset_n & slave_reset_n;

  dpml_state_t state;
  logic        stb_prev;
  logic        stb_fall;
  logic [3:0]  tmr;
  logic [7:0]  rx_byte;
  logic        rx_lastb;
  logic        rx_pend;
  logic        rx_first;
  logic [7:0]  rx_left;
  logic        tx_first;
  logic [7:0]  tx_left;
  logic        buf_ready;
  logic        push;
  logic        pop;
  logic        tail_valid;
  logic [8:0]  tail;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_prev <= 1'b1;
    end else begin
      stb_prev <= handshake_strobe_n_in;
    end
  end
  // Only the master can make a fall while we leave the line alone
  assign stb_fall = stb_prev & ~handshake_strobe_n_in
                    & ~handshake_strobe_n_oe;

  // ==========================================================
  // Two-entry buffer toward the command consumer
  // ==========================================================
  assign buf_ready = ~tail_valid;
  assign push      = rx_pend & buf_ready;
  assign pop       = cmd_valid & cmd_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid  <= 1'b0;
      cmd_data   <= 8'h00;
      cmd_last   <= 1'b0;
      tail_valid <= 1'b0;
      tail       <= 9'h000;
    end else if (pop && tail_valid) begin
      {cmd_last, cmd_data} <= tail;
      tail_valid <= 1'b0;
    end else if (pop) begin
      cmd_valid <= push;
      {cmd_last, cmd_data} <= {rx_lastb, rx_byte};
    end else if (push && !cmd_valid) begin
      cmd_valid <= 1'b1;
      {cmd_last, cmd_data} <= {rx_lastb, rx_byte};
    end else if (push) begin
      tail_valid <= 1'b1;
      tail       <= {rx_lastb, rx_byte};
    end
  end

  // ==========================================================
  // Receive side: capture, count, answer
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte  <= 8'h00;
      rx_lastb <= 1'b0;
      rx_pend  <= 1'b0;
      rx_first <= 1'b1;
      rx_left  <= 8'h00;
    end else if (state == ST_RX_IDLE && stb_fall) begin
      // Byte is valid from before the fall, so capture on it
      rx_byte <= link_data_bus_in;
      rx_pend <= 1'b1;
      if (rx_first) begin
        rx_lastb <= (link_data_bus_in <= 8'h01);
        rx_left  <= link_data_bus_in - 8'h01;
        rx_first <= (link_data_bus_in <= 8'h01);
      end else begin
        // Count still to come includes this byte
        rx_lastb <= (rx_left == 8'h01);
        rx_left  <= rx_left - 8'h01;
        rx_first <= (rx_left == 8'h01);
      end
    end else if (push) begin
      rx_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Link sequencer
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                  <= ST_RX_IDLE;
      tmr                    <= 4'h0;
      link_data_bus_out      <= `DPML_BUS_IDLE;
      link_data_bus_oe       <= 1'b0;
      handshake_strobe_n_out <= 1'b0;
      handshake_strobe_n_oe  <= 1'b0;
      ack_ready              <= 1'b0;
      tx_first               <= 1'b1;
      tx_left                <= 8'h00;
    end else begin
      unique case (state)
        ST_RX_IDLE: begin
          if (stb_fall) begin
            state <= ST_RX_LOW;
          end
        end
        ST_RX_LOW: begin
          // A full buffer holds the answer back and stalls the master
          if (handshake_strobe_n_in && !rx_pend) begin
            handshake_strobe_n_oe <= 1'b1;
            tmr   <= 4'(`DPML_STB_LOW_CYC);
            state <= ST_RX_ANS;
          end
        end
        ST_RX_ANS: begin
          if (tmr == 4'h1) begin
            handshake_strobe_n_oe <= 1'b0;
            state <= rx_first ? ST_ACK_GET : ST_RX_IDLE;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        ST_ACK_GET: begin
          if (ack_ready && ack_valid) begin
            ack_ready         <= 1'b0;
            link_data_bus_out <= ack_data;
            link_data_bus_oe  <= 1'b1;
            tx_first          <= 1'b0;
            if (tx_first) begin
              tx_left <= (ack_data == 8'h00) ? 8'h00
                                             : ack_data - 8'h01;
            end else begin
              tx_left <= tx_left - 8'h01;
            end
            tmr   <= 4'(`DPML_SETUP_CYC);
            state <= ST_TX_SET;
          end else if (ack_nak && tx_first) begin
            link_data_bus_out <= `DPML_NAK_LEN;
            link_data_bus_oe  <= 1'b1;
            tx_first          <= 1'b0;
            tx_left           <= 8'h00;
            tmr   <= 4'(`DPML_SETUP_CYC);
            state <= ST_TX_SET;
          end else begin
            ack_ready <= 1'b1;
          end
        end
        ST_TX_SET: begin
          if (tmr == 4'h1) begin
            handshake_strobe_n_oe <= 1'b1;
            tmr   <= 4'(`DPML_STB_LOW_CYC);
            state <= ST_TX_STB;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        ST_TX_STB: begin
          if (tmr == 4'h1) begin
            handshake_strobe_n_oe <= 1'b0;
            state <= ST_TX_WAIT;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        ST_TX_WAIT: begin
          if (stb_fall) begin
            state <= ST_TX_LOW;
          end
        end
        ST_TX_LOW: begin
          if (handshake_strobe_n_in) begin
            if (tx_left == 8'h00) begin
              link_data_bus_out <= `DPML_BUS_IDLE;
              tmr   <= 4'(`DPML_RELEASE_CYC);
              state <= ST_REL;
            end else begin
              state <= ST_ACK_GET;
            end
          end
        end
        ST_REL: begin
          // All ones stays driven briefly, then the slave stops driving the bus
          if (tmr == 4'h1) begin
            link_data_bus_oe <= 1'b0;
            tx_first         <= 1'b1;
            state            <= ST_RX_IDLE;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  strobe_low_len_a: assert property (
    $rose(handshake_strobe_n_oe) |->
    handshake_strobe_n_oe[*2] ##1 !handshake_strobe_n_oe)
    else $error("strobe low phase length wrong");
  data_setup_a: assert property (
    $rose(handshake_strobe_n_oe)
    && link_data_bus_oe |-> $past(link_data_bus_oe))
    else $error("data not set up before strobe");
  data_stable_a: assert property (
    handshake_strobe_n_oe
    && link_data_bus_oe |=> $stable(link_data_bus_out))
    else $error("data changed during strobe");
  answer_after_a: assert property (
    state == ST_RX_LOW
    && handshake_strobe_n_in && !rx_pend |=> handshake_strobe_n_oe)
    else $error("no answer pulse after command byte");
  nak_zero_a: assert property (
    state == ST_ACK_GET && tx_first
    && ack_nak && !(ack_ready && ack_valid) |=>
    link_data_bus_oe && link_data_bus_out == 8'h00)
    else $error("unknown command not answered with zero");
  release_ones_a: assert property (
    state == ST_TX_LOW
    && handshake_strobe_n_in && tx_left == 8'h00 |=>
    link_data_bus_oe && link_data_bus_out == 8'hff)
    else $error("bus not all ones after last ack");
  wait_master_a: assert property (
    state == ST_TX_WAIT
    && !stb_fall |=> state == ST_TX_WAIT && !handshake_strobe_n_oe)
    else $error("ack advanced without master pulse");
  rx_no_drive_a: assert property (
    state == ST_RX_IDLE
    |-> !link_data_bus_oe && !handshake_strobe_n_oe)
    else $error("slave drives link while receiving");
  buf_hold_a: assert property (
    cmd_valid && !cmd_ready
    |=> cmd_valid && $stable(cmd_data) && $stable(cmd_last))
    else $error("stalled command byte lost");

  cmd_done_c: cover property (push && rx_lastb);
  nak_sent_c: cover property (state == ST_ACK_GET && ack_nak && tx_first);
  ack_done_c: cover property (state == ST_REL ##1 state == ST_RX_IDLE);
  buf_full_c: cover property (tail_valid && rx_pend);
endmodule

/* File: dpml_master_model.sv */
// Behavioural master controller on the far side of the message link
module dpml_master_model #(
  parameter int TMO = 40
) (
  // Clock
  input  wire logic       clk,
  // Resolved link wires
  input  wire logic [7:0] bus,
  input  wire logic       stb_n,
  // Master drive
  output logic      [7:0] m_data,
  output logic            m_oe,
  output logic            m_pull,
  output logic            rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    m_data = 8'hff;
    m_oe = 1'b1;
    m_pull = 1'b0;
    rst_n = 1'b1;
  end
  // =====
  // Handshake pieces
  task automatic wait_stb(input logic lvl, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < TMO && !ok; i++) begin
      @(negedge clk);
      ok = (stb_n === lvl);
    end
  endtask
  task automatic pulse();
    @(posedge clk) m_pull <= 1'b1;
    repeat (2) @(posedge clk);
    m_pull <= 1'b0;
  endtask
  task automatic hard_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // =====
  // Byte transfers
  task automatic send(input logic [7:0] b, input bit last, output bit ok);
    @(posedge clk) m_data <= b;
    m_oe <= 1'b1;
    pulse();
    wait_stb(1'b0, ok);
    if (ok) wait_stb(1'b1, ok);
    if (!ok) hard_reset();
    else if (last) @(posedge clk) m_data <= 8'hff;
  endtask
  task automatic recv(output logic [7:0] b, output bit ok);
    // Bus handed over so the slave can answer
    @(posedge clk) m_oe <= 1'b0;
    wait_stb(1'b0, ok);
    b = bus;
    if (ok) wait_stb(1'b1, ok);
    if (ok) pulse();
    else hard_reset();
  endtask
endmodule

/* File: dpml_slave_tb.sv */
// Self-checking bench of the slave end of the message link
module dpml_slave_tb;
  import dpml_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, reset_n = 1'b0, cmd_ready = 1'b0;
  logic       ack_valid = 1'b0, ack_nak = 1'b0, stall = 1'b0;
  logic [7:0] ack_data = 8'h00, last_bus = 8'h00, s_out, m_data, got;
  logic       s_oe, s_stb_oe, s_stb_out, m_oe, m_pull, rst_n;
  logic       cmd_valid, cmd_last, ack_ready;
  logic [7:0] cmd_data;
  wire  [7:0] bus;
  wire        stb_n;
  logic [8:0] exp_q[$];
  int         n_errors = 0, compares = 0;
  bit         ok;
  // Undriven bus shows a changing pattern, strobe has a pull-up
  assign bus = s_oe ? s_out : m_oe ? m_data : ~last_bus;
  assign stb_n = ~((s_stb_oe & ~s_stb_out) | m_pull);
  always #25 clk = ~clk;
  always @(posedge clk) last_bus <= bus;
  dpml_slave dpml_slave_i (.clk(clk), .reset_n(reset_n),
    .slave_reset_n(rst_n), .link_data_bus_in(bus),
    .link_data_bus_out(s_out), .link_data_bus_oe(s_oe),
    .handshake_strobe_n_in(stb_n), .handshake_strobe_n_out(s_stb_out),
    .handshake_strobe_n_oe(s_stb_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .ack_valid(ack_valid), .ack_ready(ack_ready), .ack_data(ack_data),
    .ack_nak(ack_nak));
  dpml_master_model dpml_master_model_i (.clk(clk), .bus(bus),
    .stb_n(stb_n), .m_data(m_data), .m_oe(m_oe), .m_pull(m_pull),
    .rst_n(rst_n));
  // =====
  // Checking
  task automatic check(input logic [8:0] g, e, input string msg);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, g, e);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cmd_ready <= !stall && ($urandom_range(0, 3) != 0);
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      if (exp_q.size() == 0) check(9'h000, 9'h1ff, "extra byte");
      else check({cmd_last, cmd_data}, exp_q.pop_front(), "cmd");
    end
  end
  // =====
  // Messages
  task automatic run_cmd(input int n);
    logic [7:0] b;
    int cnt;
    cnt = (n < 2) ? 1 : n;
    ok = 1'b1;
    for (int i = 0; i < cnt && ok; i++) begin
      b = (i == 0) ? 8'(n) : 8'($urandom);
      exp_q.push_back({i == cnt - 1, b});
      dpml_master_model_i.send(b, i == cnt - 1, ok);
    end
  endtask
  task automatic run_ack(input int m, input bit nak);
    logic [7:0] a[$];
    int cnt;
    cnt = (m < 2 || nak) ? 1 : m;
    for (int i = 0; i < cnt; i++)
      a.push_back(nak ? 8'h00 : (i == 0) ? 8'(m) : 8'($urandom));
    @(posedge clk) ack_nak <= nak;
    fork
      for (int i = 0; i < cnt && !nak; i++) begin
        @(posedge clk) ack_valid <= 1'b1;
        ack_data <= a[i];
        for (int k = 0; k < 400; k++) begin
          @(posedge clk);
          if (ack_ready === 1'b1) break;
        end
        ack_valid <= 1'b0;
      end
      for (int i = 0; i < cnt; i++) begin
        dpml_master_model_i.recv(got, ok);
        check({ok, got}, {1'b1, a[i]}, "ack");
      end
    join
    ack_nak <= 1'b0;
    ok = 1'b0;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(negedge clk);
      ok = (s_oe === 1'b1 && s_out === 8'hff);
    end
    check({8'h00, ok}, 9'h001, "idle after ack");
  endtask
  // =====
  // Main sequence
  initial begin
    void'($urandom(32'hef0b76bf));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int t = 0; t < 12; t++) begin
      run_cmd(t < 4 ? t : $urandom_range(2, 6));
      check({8'h00, ok}, 9'h001, "cmd answered");
      run_ack(t < 4 ? t : $urandom_range(1, 5), t == 2 || t == 7);
    end
    // Consumer stalls: the third byte finds the buffer full
    stall <= 1'b1;
    run_cmd(4);
    check({8'h00, ok}, 9'h000, "answer held");
    exp_q.delete();
    check({s_oe, s_stb_oe, cmd_valid, 6'h00}, 9'h000, "link reset");
    stall <= 1'b0;
    run_cmd(3);
    check({8'h00, ok}, 9'h001, "cmd after reset");
    run_ack(2, 1'b0);
    check(9'(exp_q.size()), 9'h000, "bytes left");
    report_and_stop();
  end
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule
